// ---- dpllr_regs.sv ----
// Configuration register bank for the DPLL input and feedback side.
`default_nettype none

// Notes on behaviour
// R1: 3-bit reference choice resets to 0; zero means automatic pick.
// R2: Software never writes nonzero reference-choice codes; they are reserved.
// R3: Override resets 00: 00 auto, 01 free-running, 10 normal, 11 reserved.
// R4: Software sets override 01 to run as a pure synthesizer.
// R5: Reference-0 prescale is 21 bits over 0x0b..0x0d, resets 0x000014.
// R6: Reference-1 prescale is 21 bits over 0x0e..0x10, resets 0x000014.
// R7: Software writes reserved bits as zero and ignores their read value.
// R8: 24-bit loop dividers at 0x11..0x13 and 0x14..0x16, reset 0x000014.
// R9: Upper nibble of 0x17 is locked bandwidth, resets 0111, 1111 reserved.
// R10: Lower nibble of 0x17 is acquisition bandwidth, same table, resets 0111.
// R11: Software keeps the fixed pattern bytes at their shown values.
module dpllr_regs
    import dpllr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [9:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    input  wire logic       pll_locked,
    output var  logic [7:0] reg_rdata,
    output var  dpllr_cfg_t cfg,
    output var  dpllr_ctl_t ctl
);

    // Apply one byte write to the stored image.
    // Bits that sit in reserved positions are simply dropped, so whatever
    // software sends there cannot disturb a neighbouring field.
    function automatic dpllr_cfg_t cfg_write(
        input dpllr_cfg_t c,
        input logic [9:0] a,
        input logic [7:0] d
    );
        dpllr_cfg_t n;
        n = c;
        unique case (a)
            A_REF_CHOICE: begin
                n.input_ref_choice = d[7:5]; // see R1
                n.input_pattern    = d[4:0]; // see R11
            end
            A_STATE_OVR: begin
                n.override_pattern = d[5]; // see R11
                n.state_override   = dpllr_sm_t'(d[1:0]); // see R3
            end
            // Prescale ratios, most significant byte first.
            A_REF0_PRE_H: n.ref0_prescale[20:16] = d[4:0]; // see R5
            A_REF0_PRE_M: n.ref0_prescale[15:8]  = d; // see R5
            A_REF0_PRE_L: n.ref0_prescale[7:0]   = d; // see R5
            A_REF1_PRE_H: n.ref1_prescale[20:16] = d[4:0]; // see R6
            A_REF1_PRE_M: n.ref1_prescale[15:8]  = d; // see R6
            A_REF1_PRE_L: n.ref1_prescale[7:0]   = d; // see R6
            // Feedback divider ratios, full bytes each.
            A_REF0_DIV_H: n.ref0_loop_divider[23:16] = d; // see R8
            A_REF0_DIV_M: n.ref0_loop_divider[15:8]  = d; // see R8
            A_REF0_DIV_L: n.ref0_loop_divider[7:0]   = d; // see R8
            A_REF1_DIV_H: n.ref1_loop_divider[23:16] = d; // see R8
            A_REF1_DIV_M: n.ref1_loop_divider[15:8]  = d; // see R8
            A_REF1_DIV_L: n.ref1_loop_divider[7:0]   = d; // see R8
            A_LOOP_BW: begin
                n.locked_bandwidth  = d[7:4]; // see R9
                n.acquire_bandwidth = d[3:0]; // see R10
            end
            A_DAMP_GAIN: begin
                n.locked_damping  = d[7:5];
                n.acquire_damping = d[4:2];
                n.loop_gain       = d[1:0];
            end
            // Fixed bytes stay writable so a bad write can be repaired.
            A_FIXED_ONES_A: n.fixed_ones[0] = d; // see R11
            A_FIXED_ONES_B: n.fixed_ones[1] = d; // see R11
            A_FIXED_ONES_C: n.fixed_ones[2] = d; // see R11
            A_FIXED_ONES_D: n.fixed_ones[3] = d; // see R11
            A_QUICK_ACQ:    n.quick_acquire = d[0];
            A_LOCK_SET:     n.lock_setting  = d;
            // Delta-sigma integer and fraction words.
            A_MOD_INT_H:  n.modulator_integer[8]         = d[0];
            A_MOD_INT_L:  n.modulator_integer[7:0]       = d;
            A_MOD_FRAC_H: n.modulator_fraction[20:16]    = d[4:0];
            A_MOD_FRAC_M: n.modulator_fraction[15:8]     = d;
            A_MOD_FRAC_L: n.modulator_fraction[7:0]      = d;
            A_FIXED_ONE:  n.fixed_one_value              = d; // see R11
            A_MOD_DITHER: begin
                n.modulator_order = d[7:6];
                n.oscillator_gain = d[5:4];
                n.dither_gain     = d[2:0];
            end
            // Reserved and unmapped bytes ignore writes.
            default: n = c; // see R7
        endcase
        return n;
    endfunction

    // Assemble the byte that a read at one offset returns.
    // Reserved positions read as zero; software must not rely on that.
    function automatic logic [7:0] cfg_read(
        input dpllr_cfg_t c,
        input logic [9:0] a
    );
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            A_REF_CHOICE: r = {c.input_ref_choice, c.input_pattern};
            A_STATE_OVR: begin
                r = {2'h0, c.override_pattern, 3'h0, c.state_override};
            end
            A_REF0_PRE_H: r = {3'h0, c.ref0_prescale[20:16]};
            A_REF0_PRE_M: r = c.ref0_prescale[15:8];
            A_REF0_PRE_L: r = c.ref0_prescale[7:0];
            A_REF1_PRE_H: r = {3'h0, c.ref1_prescale[20:16]};
            A_REF1_PRE_M: r = c.ref1_prescale[15:8];
            A_REF1_PRE_L: r = c.ref1_prescale[7:0];
            A_REF0_DIV_H: r = c.ref0_loop_divider[23:16];
            A_REF0_DIV_M: r = c.ref0_loop_divider[15:8];
            A_REF0_DIV_L: r = c.ref0_loop_divider[7:0];
            A_REF1_DIV_H: r = c.ref1_loop_divider[23:16];
            A_REF1_DIV_M: r = c.ref1_loop_divider[15:8];
            A_REF1_DIV_L: r = c.ref1_loop_divider[7:0];
            A_LOOP_BW: begin
                r = {c.locked_bandwidth, c.acquire_bandwidth};
            end
            A_DAMP_GAIN: begin
                r = {c.locked_damping, c.acquire_damping, c.loop_gain};
            end
            A_FIXED_ONES_A: r = c.fixed_ones[0];
            A_FIXED_ONES_B: r = c.fixed_ones[1];
            A_FIXED_ONES_C: r = c.fixed_ones[2];
            A_FIXED_ONES_D: r = c.fixed_ones[3];
            A_QUICK_ACQ:    r = {7'h00, c.quick_acquire};
            A_LOCK_SET:     r = c.lock_setting;
            A_MOD_INT_H:    r = {7'h00, c.modulator_integer[8]};
            A_MOD_INT_L:    r = c.modulator_integer[7:0];
            A_MOD_FRAC_H:   r = {3'h0, c.modulator_fraction[20:16]};
            A_MOD_FRAC_M:   r = c.modulator_fraction[15:8];
            A_MOD_FRAC_L:   r = c.modulator_fraction[7:0];
            A_FIXED_ONE:    r = c.fixed_one_value;
            A_MOD_DITHER: begin
                r = {c.modulator_order, c.oscillator_gain, 1'b0,
                     c.dither_gain};
            end
            default: r = 8'h00; // see R7
        endcase
        return r;
    endfunction

    // Write and read selection.
    // A read in the same cycle as a write returns the old contents, which
    // keeps the read path free of the write decode.
    dpllr_cfg_t next_cfg;
    logic [7:0] next_rdata;

    assign next_cfg   = reg_wr ? cfg_write(cfg, reg_addr, reg_wdata) : cfg;
    assign next_rdata = reg_rd ? cfg_read(cfg, reg_addr) : reg_rdata;

    // Decoded controls for the core.
    // They are taken from next_cfg and registered, so every control output
    // leaves a flip-flop and changes in the same cycle as the stored field.
    logic       next_auto_ref;
    logic       next_force_free;
    logic       next_force_normal;
    logic [3:0] next_bandwidth;
    logic [2:0] next_damping;

    // Zero selects the reference automatically; the reserved codes get no
    // meaning of their own and simply leave the choice to software's care.
    assign next_auto_ref =
        (next_cfg.input_ref_choice == REF_CHOICE_AUTO); // see R1

    // The reserved override code forces nothing, like the automatic code.
    assign next_force_free =
        (next_cfg.state_override == DPLLR_SM_FREE_RUNNING); // see R3
    assign next_force_normal =
        (next_cfg.state_override == DPLLR_SM_NORMAL); // see R3

    // Bandwidth and damping follow the lock state of the loop.
    // The reserved bandwidth code is passed through unchanged; the core
    // decides what to make of it.
    assign next_bandwidth = pll_locked ? next_cfg.locked_bandwidth // see R9
                                       : next_cfg.acquire_bandwidth; // see R10
    assign next_damping   = pll_locked ? next_cfg.locked_damping
                                       : next_cfg.acquire_damping;

    // Configuration storage with power-on defaults.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg <= CFG_RESET; // see R5
        end else begin
            cfg <= next_cfg;
        end
    end

    // Read data register; it holds its value between reads.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // Registered control outputs.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl <= CTL_RESET;
        end else begin
            ctl.auto_ref_select    <= next_auto_ref;
            ctl.force_free_running <= next_force_free;
            ctl.force_normal       <= next_force_normal;
            ctl.active_bandwidth   <= next_bandwidth;
            ctl.active_damping     <= next_damping;
        end
    end

endmodule
`default_nettype wire

// ---- dpllr_pkg.sv ----
// Package with offsets, reset values and field types of the DPLL input bank.
`default_nettype none
package dpllr_pkg;

    // Byte offsets within the serial register space.
    localparam logic [9:0] A_REF_CHOICE   = 10'h008;
    localparam logic [9:0] A_RSVD_INPUT   = 10'h009;
    localparam logic [9:0] A_STATE_OVR    = 10'h00a;
    localparam logic [9:0] A_REF0_PRE_H   = 10'h00b;
    localparam logic [9:0] A_REF0_PRE_M   = 10'h00c;
    localparam logic [9:0] A_REF0_PRE_L   = 10'h00d;
    localparam logic [9:0] A_REF1_PRE_H   = 10'h00e;
    localparam logic [9:0] A_REF1_PRE_M   = 10'h00f;
    localparam logic [9:0] A_REF1_PRE_L   = 10'h010;
    localparam logic [9:0] A_REF0_DIV_H   = 10'h011;
    localparam logic [9:0] A_REF0_DIV_M   = 10'h012;
    localparam logic [9:0] A_REF0_DIV_L   = 10'h013;
    localparam logic [9:0] A_REF1_DIV_H   = 10'h014;
    localparam logic [9:0] A_REF1_DIV_M   = 10'h015;
    localparam logic [9:0] A_REF1_DIV_L   = 10'h016;
    localparam logic [9:0] A_LOOP_BW      = 10'h017;
    localparam logic [9:0] A_DAMP_GAIN    = 10'h018;
    localparam logic [9:0] A_FIXED_ONES_A = 10'h01f;
    localparam logic [9:0] A_FIXED_ONES_B = 10'h020;
    localparam logic [9:0] A_FIXED_ONES_C = 10'h021;
    localparam logic [9:0] A_FIXED_ONES_D = 10'h022;
    localparam logic [9:0] A_QUICK_ACQ    = 10'h023;
    localparam logic [9:0] A_LOCK_SET     = 10'h024;
    localparam logic [9:0] A_MOD_INT_H    = 10'h025;
    localparam logic [9:0] A_MOD_INT_L    = 10'h026;
    localparam logic [9:0] A_MOD_FRAC_H   = 10'h028;
    localparam logic [9:0] A_MOD_FRAC_M   = 10'h029;
    localparam logic [9:0] A_MOD_FRAC_L   = 10'h02a;
    localparam logic [9:0] A_FIXED_ONE    = 10'h02c;
    localparam logic [9:0] A_MOD_DITHER   = 10'h02f;

    // State-machine override codes.
    typedef enum logic [1:0] {
        DPLLR_SM_AUTO         = 2'b00,
        DPLLR_SM_FREE_RUNNING = 2'b01,
        DPLLR_SM_NORMAL       = 2'b10,
        DPLLR_SM_RESERVED     = 2'b11
    } dpllr_sm_t;

    localparam logic [2:0] REF_CHOICE_AUTO = 3'h0;

    // Stored configuration, one field per documented bit group.
    typedef struct packed {
        logic [2:0]      input_ref_choice;
        logic [4:0]      input_pattern;
        logic            override_pattern;
        dpllr_sm_t       state_override;
        logic [20:0]     ref0_prescale;
        logic [20:0]     ref1_prescale;
        logic [23:0]     ref0_loop_divider;
        logic [23:0]     ref1_loop_divider;
        logic [3:0]      locked_bandwidth;
        logic [3:0]      acquire_bandwidth;
        logic [2:0]      locked_damping;
        logic [2:0]      acquire_damping;
        logic [1:0]      loop_gain;
        logic [3:0][7:0] fixed_ones;
        logic            quick_acquire;
        logic [7:0]      lock_setting;
        logic [8:0]      modulator_integer;
        logic [20:0]     modulator_fraction;
        logic [7:0]      fixed_one_value;
        logic [1:0]      modulator_order;
        logic [1:0]      oscillator_gain;
        logic [2:0]      dither_gain;
    } dpllr_cfg_t;

    // Decoded controls handed to the PLL core.
    typedef struct packed {
        logic       auto_ref_select;
        logic       force_free_running;
        logic       force_normal;
        logic [3:0] active_bandwidth;
        logic [2:0] active_damping;
    } dpllr_ctl_t;

    // Power-on values.
    localparam dpllr_cfg_t CFG_RESET = '{
        input_ref_choice:   REF_CHOICE_AUTO,
        input_pattern:      5'h17,
        override_pattern:   1'b1,
        state_override:     DPLLR_SM_AUTO,
        ref0_prescale:      21'h000014,
        ref1_prescale:      21'h000014,
        ref0_loop_divider:  24'h000014,
        ref1_loop_divider:  24'h000014,
        locked_bandwidth:   4'h7,
        acquire_bandwidth:  4'h7,
        locked_damping:     3'h0,
        acquire_damping:    3'h0,
        loop_gain:          2'h0,
        fixed_ones:         32'hffffffff,
        quick_acquire:      1'b0,
        lock_setting:       8'h00,
        modulator_integer:  9'h000,
        modulator_fraction: 21'h000000,
        fixed_one_value:    8'h01,
        modulator_order:    2'h0,
        oscillator_gain:    2'h0,
        dither_gain:        3'h0
    };

    localparam dpllr_ctl_t CTL_RESET = '{
        auto_ref_select:    1'b1,
        force_free_running: 1'b0,
        force_normal:       1'b0,
        active_bandwidth:   4'h7,
        active_damping:     3'h0
    };

endpackage
`default_nettype wire

// ---- dpllr_regs_checker.sv ----
// Port checker for the DPLL input and feedback register bank.
`default_nettype none
module dpllr_regs_checker
    import dpllr_pkg::*;
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [9:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic       pll_locked,
    input wire logic [7:0] reg_rdata,
    input wire dpllr_cfg_t cfg,
    input wire dpllr_ctl_t ctl
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Write and read strobes aimed at one byte offset.
    sequence s_wr(logic [9:0] a);
        reg_wr && reg_addr == a;
    endsequence
    sequence s_rd(logic [9:0] a);
        reg_rd && reg_addr == a;
    endsequence

    // A byte write lands in its slice on the next cycle.
    property p_ref0_prescale_low;
        s_wr(A_REF0_PRE_L) |=> cfg.ref0_prescale[7:0] == $past(reg_wdata);
    endproperty
    property p_ref1_prescale_high;
        s_wr(A_REF1_PRE_H) |=>
            cfg.ref1_prescale[20:16] == $past(reg_wdata[4:0]);
    endproperty
    property p_div0_high;
        s_wr(A_REF0_DIV_H) |=>
            cfg.ref0_loop_divider[23:16] == $past(reg_wdata);
    endproperty
    property p_div1_low;
        s_wr(A_REF1_DIV_L) |=>
            cfg.ref1_loop_divider[7:0] == $past(reg_wdata);
    endproperty
    property p_bw_write;
        s_wr(A_LOOP_BW) |=>
            {cfg.locked_bandwidth, cfg.acquire_bandwidth} == $past(reg_wdata);
    endproperty
    // A read returns the value from before any write in the same cycle.
    property p_bw_read;
        s_rd(A_LOOP_BW) |=> reg_rdata ==
            {$past(cfg.locked_bandwidth), $past(cfg.acquire_bandwidth)};
    endproperty
    // Decoded controls follow the stored fields and the lock input.
    property p_bw_active;
        ctl.active_bandwidth == ($past(pll_locked) ?
            cfg.locked_bandwidth : cfg.acquire_bandwidth);
    endproperty
    property p_state_force;
        ctl.force_free_running == (cfg.state_override == DPLLR_SM_FREE_RUNNING)
        && ctl.force_normal == (cfg.state_override == DPLLR_SM_NORMAL);
    endproperty
    property p_auto_ref;
        ctl.auto_ref_select == (cfg.input_ref_choice == REF_CHOICE_AUTO);
    endproperty

    a_ref0_prescale_low: assert property (p_ref0_prescale_low)
        else $error("ref0 prescale low byte not stored");
    a_ref1_prescale_high: assert property (p_ref1_prescale_high)
        else $error("ref1 prescale high bits not stored");
    a_div0_high: assert property (p_div0_high)
        else $error("ref0 loop divider high byte not stored");
    a_div1_low: assert property (p_div1_low)
        else $error("ref1 loop divider low byte not stored");
    a_bw_write: assert property (p_bw_write)
        else $error("bandwidth byte not stored");
    a_bw_read: assert property (p_bw_read)
        else $error("bandwidth byte read wrong");
    a_bw_active: assert property (p_bw_active)
        else $error("active bandwidth wrong for lock state");
    a_state_force: assert property (p_state_force)
        else $error("state override decode wrong");
    a_auto_ref: assert property (p_auto_ref)
        else $error("automatic reference decode wrong");
endmodule

bind dpllr_regs dpllr_regs_checker dpllr_regs_checker_i (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .pll_locked(pll_locked),
    .reg_rdata(reg_rdata), .cfg(cfg), .ctl(ctl)
);
`default_nettype wire

// ---- dpllr_regs_bench.sv ----
// Self-checking bench for the DPLL input and feedback register bank.
`default_nettype none
module dpllr_regs_bench
    import dpllr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic       reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_rd = 1'b0;
    logic       pll_locked = 1'b0;
    logic [7:0] reg_rdata;
    dpllr_cfg_t cfg;
    dpllr_ctl_t ctl;
    logic [7:0] img [0:1023];
    logic [9:0] addr_r;
    int         fail_count = 0;
    int         samples_checked = 0;

    // Free-running 50 MHz clock.
    always #10 clk = ~clk;

    dpllr_regs dpllr_regs_i (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .pll_locked(pll_locked),
        .reg_rdata(reg_rdata), .cfg(cfg), .ctl(ctl)
    );

    // Storage bits of each byte; reserved and unmapped places hold none.
    function automatic logic [7:0] wmask(input logic [9:0] a);
        if (a < 10'h008 || a > 10'h02f) return 8'h00;
        case (a)
            10'h009, 10'h019, 10'h01a, 10'h01b, 10'h01c, 10'h01d,
            10'h01e, 10'h027, 10'h02b, 10'h02d, 10'h02e: return 8'h00;
            10'h00a: return 8'h23;
            10'h00b, 10'h00e, 10'h028: return 8'h1f;
            10'h023, 10'h025: return 8'h01;
            10'h02f: return 8'hf7;
            default: return 8'hff;
        endcase
    endfunction

    // Power-on byte image.
    function automatic logic [7:0] rval(input logic [9:0] a);
        case (a)
            10'h008: return 8'h17;
            10'h00a: return 8'h20;
            10'h00d, 10'h010, 10'h013, 10'h016: return 8'h14;
            10'h017: return 8'h77;
            10'h01f, 10'h020, 10'h021, 10'h022: return 8'hff;
            10'h02c: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction

    // Turns a random byte into one that software may legally write.
    // Reserved bits go out as zero and fixed pattern bits keep their value.
    function automatic logic [7:0] legal(input logic [9:0] a,
                                         input logic [7:0] d);
        case (a)
            10'h008: return rval(a);
            10'h00a: return (d & 8'h03) | 8'h20;
            10'h01f, 10'h020, 10'h021, 10'h022, 10'h02c: begin
                return rval(a);
            end
            default: return d & wmask(a);
        endcase
    endfunction

    task automatic chk(input string n, input logic [31:0] g,
                       input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask

    // One write; the lock input is stirred so the bandwidth pick moves.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        pll_locked <= 1'($urandom);
        @(posedge clk);
        reg_wr <= 1'b0;
        img[a] = d & wmask(a);
        #1;
    endtask

    task automatic rd(input logic [9:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, img[a]);
    endtask

    task automatic chk_cfg();
        chk("ref0_prescale", cfg.ref0_prescale,
            {img['h0b][4:0], img['h0c], img['h0d]});
        chk("ref1_prescale", cfg.ref1_prescale,
            {img['h0e][4:0], img['h0f], img['h10]});
        chk("ref0_loop_divider", cfg.ref0_loop_divider,
            {img['h11], img['h12], img['h13]});
        chk("ref1_loop_divider", cfg.ref1_loop_divider,
            {img['h14], img['h15], img['h16]});
    endtask

    // Reset image, read back byte by byte from the first edge after release.
    task automatic reset_check();
        for (int i = 0; i < 1024; i++) img[i] = rval(10'(i));
        rstn <= 1'b1;
        for (int i = 6; i < 'h32; i++) begin
            rd(10'(i));
        end
        chk_cfg();
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole run needs well under a tenth of this.
    initial begin
        #400000;
        fail_count++;
        results();
    end

    initial begin
        void'($urandom(48));
        repeat (16) @(posedge clk);
        reset_check();
        // Every override code with the fixed bit kept, then synthesizer use.
        for (int i = 0; i < 4; i++) begin
            wr(A_STATE_OVR, 8'h20 | 8'(i));
            chk("force_free_running", ctl.force_free_running,
                i == 1);
            chk("force_normal", ctl.force_normal, i == 2);
        end
        wr(A_STATE_OVR, 8'h21);
        chk("synth_free_running", ctl.force_free_running, 1'b1);
        // Software may only load the automatic reference code.
        wr(A_REF_CHOICE, {REF_CHOICE_AUTO, 5'h17});
        chk("auto_ref_select", ctl.auto_ref_select, 1'b1);
        // Reserved bandwidth code passes; lock input picks the nibble.
        wr(A_LOOP_BW, 8'hf3);
        wr(A_DAMP_GAIN, 8'ha4);
        for (int l = 0; l < 2; l++) begin
            @(posedge clk);
            pll_locked <= 1'(l);
            repeat (2) @(posedge clk);
            #1;
            chk("active_bandwidth", ctl.active_bandwidth,
                l ? 4'hf : 4'h3);
            chk("active_damping", ctl.active_damping, l ? 3'h5 : 3'h1);
        end
        // Read and write of one byte in the same cycle sees the old value.
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b1;
        reg_addr <= A_LOOP_BW;
        reg_wdata <= 8'h5a;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        chk("rdata_old", reg_rdata, img[A_LOOP_BW]);
        img[A_LOOP_BW] = 8'h5a;
        wr(10'h3ff, 8'h00);
        rd(10'h3ff);
        // Random legal traffic over mapped, reserved and unmapped bytes.
        repeat (120) begin
            addr_r = 10'($urandom_range(10'h031, 10'h006));
            wr(addr_r, legal(addr_r, 8'($urandom)));
            rd(10'($urandom_range(10'h031, 10'h006)));
        end
        chk_cfg();
        // A second reset in mid-run restores the power-on image.
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        reset_check();
        results();
    end
endmodule
`default_nettype wire
